/* File: pkg/s2c_defines.svh */
`ifndef S2C_DEFINES_SVH
`define S2C_DEFINES_SVH

// register word indices; byte address is four times the index
`define S2C_IDX_CTRL_A      30'h0000_0047
`define S2C_IDX_CTRL_B      30'h0000_0048
`define S2C_IDX_STATUS      30'h0000_0049

// synth2_control_a fields
`define S2C_A_DIV_MSB       4
`define S2C_A_DIV_LSB       2
`define S2C_A_SYNC_BIT      1
`define S2C_A_PDN_BIT       0

// synth2_control_b fields
`define S2C_B_RSVD_BIT      5
`define S2C_B_DBL_BIT       4
`define S2C_B_PUMP_MSB      3
`define S2C_B_PUMP_LSB      0

// status fields
`define S2C_S_ENABLED_BIT   0
`define S2C_S_BUSY_BIT      1
`define S2C_S_LOCKED_BIT    2
`define S2C_S_CAL_RST_BIT   3
`define S2C_S_COUNT_MSB     15
`define S2C_S_COUNT_LSB     8

// reset values
`define S2C_RST_POST_DIV    3'h7
`define S2C_RST_RESYNC_EN   1'h1
`define S2C_RST_PDN         1'h0
`define S2C_RST_DBL         1'h1
`define S2C_RST_PUMP        4'h8
`define S2C_RST_RSVD_B5     1'h0

// decode constants
`define S2C_DIV_MIN_RATIO   4'h2
`define S2C_DIV_LOW_CODE    3'h1
`define S2C_PUMP_LIN_MAX    4'h7
`define S2C_PUMP_TOP_CODE   4'h8
`define S2C_PUMP_TOP_UNITS  5'h10
`define S2C_PUMP_OFF_UNITS  5'h00

// bus constants
`define S2C_HTRANS_BUSY_BIT 1
`define S2C_HRESP_OKAY      1'h0

// calibration length in clocks
`define S2C_CAL_CYCLES      1024

`endif

/* File: pkg/s2c_pkg.sv */
package s2c_pkg;

  typedef struct packed {
    logic        wr;
    logic [29:0] idx;
    logic [31:0] wdata;
  } s2c_bus_req_type;

  typedef struct packed {
    logic [2:0] post_div;
    logic       resync_en;
    logic       pdn;
  } s2c_ctrl_a_type;

  typedef struct packed {
    logic       rsvd_b5;
    logic       dbl;
    logic [3:0] pump;
  } s2c_ctrl_b_type;

  typedef struct packed {
    logic enabled;
    logic cal_reset;
    logic busy;
    logic locked;
  } s2c_cal_stat_type;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT
  } s2c_bus_state_type;

  typedef enum logic [1:0] {
    CAL_HELD,
    CAL_RUN,
    CAL_LOCKED
  } s2c_cal_state_type;

endpackage

/* File: hdl/s2c_ahb_slave.sv */
`timescale 1ns/100ps
`include "s2c_defines.svh"

module s2c_ahb_slave (
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // ahb-lite slave side
  input  wire logic                   hsel_in,
  input  wire logic [31:0]            haddr_in,
  input  wire logic [1:0]             htrans_in,
  input  wire logic                   hwrite_in,
  input  wire logic [31:0]            hwdata_in,
  input  wire logic                   hready_in,
  output logic                        hreadyout_out,
  output logic [31:0]                 hrdata_out,
  output logic                        hresp_out,
  // register side
  output s2c_pkg::s2c_bus_req_type    req_out,
  input  wire logic [31:0]            rd_data_in
);

  s2c_pkg::s2c_bus_state_type state_r, state_nxt;
  logic [29:0]                idx_r, idx_nxt;
  logic                       ready_r, ready_nxt;
  logic [31:0]                rdata_r, rdata_nxt;
  logic                       take;

  assign take = hsel_in & hready_in & htrans_in[`S2C_HTRANS_BUSY_BIT];

  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    ready_nxt = ready_r;
    rdata_nxt = rdata_r;
    // reads take one wait state so hrdata always leaves a flop
    if (state_r == s2c_pkg::BUS_READ_WAIT) begin
      rdata_nxt = rd_data_in;
      ready_nxt = 1'b1;
      state_nxt = s2c_pkg::BUS_IDLE;
    end else if (take) begin
      idx_nxt   = haddr_in[31:2];
      state_nxt = hwrite_in ? s2c_pkg::BUS_WRITE : s2c_pkg::BUS_READ_WAIT;
      ready_nxt = hwrite_in;
    end else begin
      state_nxt = s2c_pkg::BUS_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= s2c_pkg::BUS_IDLE;
      idx_r   <= 30'h0000_0000;
      ready_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      ready_r <= ready_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign req_out.wr    = (state_r == s2c_pkg::BUS_WRITE);
  assign req_out.idx   = idx_r;
  assign req_out.wdata = hwdata_in;
  assign hreadyout_out = ready_r;
  assign hrdata_out    = rdata_r;
  assign hresp_out     = `S2C_HRESP_OKAY;

endmodule

/* File: hdl/s2c_cal_seq.sv */
`timescale 1ns/100ps
`include "s2c_defines.svh"

module s2c_cal_seq #(
  parameter int CAL_CYCLES = `S2C_CAL_CYCLES
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   power_down_in,
  output s2c_pkg::s2c_cal_stat_type   stat_out
);

  localparam int CW = $clog2(CAL_CYCLES);

  if (CAL_CYCLES < 2) begin : g_bad_cal
    $error("s2c_cal_seq: CAL_CYCLES must be at least 2");
  end

  s2c_pkg::s2c_cal_state_type state_r, state_nxt;
  logic [CW-1:0]              cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (power_down_in) begin
      state_nxt = s2c_pkg::CAL_HELD;
    end else begin
      case (state_r)
        s2c_pkg::CAL_HELD: begin
          // leaving power-down restarts calibration by itself
          state_nxt = s2c_pkg::CAL_RUN;
          cnt_nxt   = CW'(CAL_CYCLES - 1);
        end
        s2c_pkg::CAL_RUN: begin
          if (cnt_r == '0) begin
            state_nxt = s2c_pkg::CAL_LOCKED;
          end else begin
            cnt_nxt = cnt_r - CW'(1);
          end
        end
        s2c_pkg::CAL_LOCKED: begin
          state_nxt = s2c_pkg::CAL_LOCKED;
        end
        default: begin
          state_nxt = s2c_pkg::CAL_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= s2c_pkg::CAL_HELD;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign stat_out.enabled   = (state_r != s2c_pkg::CAL_HELD);
  assign stat_out.cal_reset = (state_r == s2c_pkg::CAL_HELD);
  assign stat_out.busy      = (state_r == s2c_pkg::CAL_RUN);
  assign stat_out.locked    = (state_r == s2c_pkg::CAL_LOCKED);

endmodule

/* File: hdl/s2c_top.sv */
// Summary of operation
// RULE1 - post-divider codes 0,1 divide by two; else code+1
// RULE2 - sync event resyncs synth2 channels when enabled
// RULE3 - power-down disables synth2, holds calibration reset
// RULE4 - clearing power-down re-enables and auto-calibrates
// RULE5 - power-down reset zero: enable and calibrate after reset
// RULE6 - doubler enabled when bit set, else bypassed
// RULE7 - pump codes 1-7 give 0.4mA steps; 8 gives 6.4
// RULE8 - reserved bits read zero; writable one just stored
`timescale 1ns/100ps
`include "s2c_defines.svh"

module s2c_top #(
  parameter int NUM_CH     = 8,
  parameter int CAL_CYCLES = `S2C_CAL_CYCLES
) (
  // clock and reset
  input  wire logic              REF_CLK_IN,
  input  wire logic              RESETN_IN,
  // ahb-lite register port
  input  wire logic              HSEL_IN,
  input  wire logic [31:0]       HADDR_IN,
  input  wire logic [1:0]        HTRANS_IN,
  input  wire logic              HWRITE_IN,
  input  wire logic [2:0]        HSIZE_IN,
  input  wire logic [31:0]       HWDATA_IN,
  input  wire logic              HREADY_IN,
  output logic                   HREADYOUT_OUT,
  output logic [31:0]            HRDATA_OUT,
  output logic                   HRESP_OUT,
  // synchronization
  input  wire logic              SYNC_EVENT_IN,
  input  wire logic [NUM_CH-1:0] CH_FROM_SYNTH2_IN,
  output logic [NUM_CH-1:0]      CH_RESYNC_OUT,
  // analog synthesizer controls
  output logic                   SYNTH2_ENABLE_OUT,
  output logic                   SYNTH2_CAL_RESET_OUT,
  output logic                   SYNTH2_CAL_BUSY_OUT,
  output logic [3:0]             SYNTH2_POST_DIV_RATIO_OUT,
  output logic [4:0]             SYNTH2_PUMP_CURRENT_OUT,
  output logic                   SECONDARY_REF_DOUBLER_EN_OUT
);

  if (NUM_CH < 1 || NUM_CH > 32) begin : g_bad_ch
    $error("s2c_top: NUM_CH must be 1 to 32");
  end
  if (CAL_CYCLES < 2 || CAL_CYCLES > 4096) begin : g_bad_cal
    $error("s2c_top: CAL_CYCLES must be 2 to 4096");
  end

  // ratio from the three-bit post-divider code
  function automatic logic [3:0] post_div_ratio(input logic [2:0] code);
    logic [3:0] r;
    r = {1'b0, code} + 4'h1;
    if (code <= `S2C_DIV_LOW_CODE) begin
      r = `S2C_DIV_MIN_RATIO; // RULE1
    end
    return r;
  endfunction

  // pump current in units of 0.4 mA
  function automatic logic [4:0] pump_units(input logic [3:0] code);
    logic [4:0] u;
    u = `S2C_PUMP_OFF_UNITS;
    if (code == `S2C_PUMP_TOP_CODE) begin
      u = `S2C_PUMP_TOP_UNITS; // RULE7
    end else if (code <= `S2C_PUMP_LIN_MAX) begin
      u = {1'b0, code}; // RULE7
    end
    return u;
  endfunction

  // word-index match, shared by the read and write decode
  function automatic logic word_hit(input logic [29:0] idx, input logic [29:0] want);
    return (idx == want);
  endfunction

  // split a written word into ctrl_a; reserved bits are dropped
  function automatic s2c_pkg::s2c_ctrl_a_type fields_a(input logic [31:0] w);
    s2c_pkg::s2c_ctrl_a_type a;
    a.post_div  = w[`S2C_A_DIV_MSB:`S2C_A_DIV_LSB];
    a.resync_en = w[`S2C_A_SYNC_BIT];
    a.pdn       = w[`S2C_A_PDN_BIT]; // RULE3 RULE4
    return a;
  endfunction

  // split a written word into ctrl_b; bit 5 is kept as plain storage
  function automatic s2c_pkg::s2c_ctrl_b_type fields_b(input logic [31:0] w);
    s2c_pkg::s2c_ctrl_b_type b;
    b.rsvd_b5 = w[`S2C_B_RSVD_BIT]; // RULE8
    b.dbl     = w[`S2C_B_DBL_BIT];
    b.pump    = w[`S2C_B_PUMP_MSB:`S2C_B_PUMP_LSB];
    return b;
  endfunction

  // ctrl_a as software reads it; reserved bits stay zero
  function automatic logic [31:0] word_a(input s2c_pkg::s2c_ctrl_a_type a);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`S2C_A_DIV_MSB:`S2C_A_DIV_LSB] = a.post_div;
    w[`S2C_A_SYNC_BIT]              = a.resync_en;
    w[`S2C_A_PDN_BIT]               = a.pdn;
    return w;
  endfunction

  // ctrl_b as software reads it; bit 5 is stored but drives nothing
  function automatic logic [31:0] word_b(input s2c_pkg::s2c_ctrl_b_type b);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`S2C_B_RSVD_BIT]                = b.rsvd_b5; // RULE8
    w[`S2C_B_DBL_BIT]                 = b.dbl;
    w[`S2C_B_PUMP_MSB:`S2C_B_PUMP_LSB] = b.pump;
    return w;
  endfunction

  // status word: calibration state and applied resync count
  function automatic logic [31:0] word_s(input s2c_pkg::s2c_cal_stat_type s,
                                         input logic [7:0]                cnt);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`S2C_S_ENABLED_BIT]                 = s.enabled;
    w[`S2C_S_BUSY_BIT]                    = s.busy;
    w[`S2C_S_LOCKED_BIT]                  = s.locked;
    w[`S2C_S_CAL_RST_BIT]                 = s.cal_reset;
    w[`S2C_S_COUNT_MSB:`S2C_S_COUNT_LSB] = cnt;
    return w;
  endfunction

  s2c_pkg::s2c_bus_req_type  req;
  s2c_pkg::s2c_cal_stat_type cal_stat;
  logic [31:0]               rd_data;
  logic                      sel_a;
  logic                      sel_b;
  logic                      sel_s;
  logic                      wr_a;
  logic                      wr_b;
  logic [NUM_CH-1:0]         ch_resync_r, ch_resync_nxt;
  logic [7:0]                resync_cnt_r, resync_cnt_nxt;
  logic                      bus_resp;
  logic                      resp_r, resp_nxt;

  // bus front end
  s2c_ahb_slave u_bus (
    .clk_in        (REF_CLK_IN),
    .rst_n_in      (RESETN_IN),
    .hsel_in       (HSEL_IN),
    .haddr_in      (HADDR_IN),
    .htrans_in     (HTRANS_IN),
    .hwrite_in     (HWRITE_IN),
    .hwdata_in     (HWDATA_IN),
    .hready_in     (HREADY_IN),
    .hreadyout_out (HREADYOUT_OUT),
    .hrdata_out    (HRDATA_OUT),
    .hresp_out     (bus_resp),
    .req_out       (req),
    .rd_data_in    (rd_data)
  );

  assign sel_a = word_hit(req.idx, `S2C_IDX_CTRL_A);
  assign sel_b = word_hit(req.idx, `S2C_IDX_CTRL_B);
  assign sel_s = word_hit(req.idx, `S2C_IDX_STATUS);
  assign wr_a  = req.wr & sel_a;
  assign wr_b  = req.wr & sel_b;

  // control registers
  s2c_pkg::s2c_ctrl_a_type ctrl_a_r, ctrl_a_nxt;
  s2c_pkg::s2c_ctrl_b_type ctrl_b_r, ctrl_b_nxt;

  always_comb begin
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    if (wr_a) begin
      ctrl_a_nxt = fields_a(req.wdata); // RULE3 RULE4
    end
    if (wr_b) begin
      ctrl_b_nxt = fields_b(req.wdata); // RULE8
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      // pdn resets low, so synth2 comes up and calibrates unasked
      ctrl_a_r.post_div  <= `S2C_RST_POST_DIV;
      ctrl_a_r.resync_en <= `S2C_RST_RESYNC_EN;
      ctrl_a_r.pdn       <= `S2C_RST_PDN; // RULE5
      ctrl_b_r.rsvd_b5   <= `S2C_RST_RSVD_B5;
      ctrl_b_r.dbl       <= `S2C_RST_DBL;
      ctrl_b_r.pump      <= `S2C_RST_PUMP;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
    end
  end

  // read mux; unmapped words and reserved bits read as zero, except ctrl_b bit 5, which reads back as stored
  always_comb begin
    rd_data = 32'h0000_0000; // RULE8
    if (sel_a) begin
      rd_data = word_a(ctrl_a_r);
    end else if (sel_b) begin
      rd_data = word_b(ctrl_b_r); // RULE8
    end else if (sel_s) begin
      rd_data = word_s(cal_stat, resync_cnt_r);
    end
  end

  // calibration sequencer follows the stored power-down bit
  s2c_cal_seq #(
    .CAL_CYCLES (CAL_CYCLES)
  ) u_cal (
    .clk_in        (REF_CLK_IN),
    .rst_n_in      (RESETN_IN),
    .power_down_in (ctrl_a_r.pdn), // RULE3 RULE4 RULE5
    .stat_out      (cal_stat)
  );

  // sync event pin: two flops, then an edge detect on the second
  logic sync_meta_r, sync_meta_nxt;
  logic sync_safe_r, sync_safe_nxt;
  logic sync_last_r, sync_last_nxt;
  logic sync_rise;

  always_comb begin
    sync_meta_nxt = SYNC_EVENT_IN;
    sync_safe_nxt = sync_meta_r;
    sync_last_nxt = sync_safe_r;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync_meta_r <= 1'b0;
      sync_safe_r <= 1'b0;
      sync_last_r <= 1'b0;
    end else begin
      sync_meta_r <= sync_meta_nxt;
      sync_safe_r <= sync_safe_nxt;
      sync_last_r <= sync_last_nxt;
    end
  end

  // the last flop resets low like the idle pin, so reset makes no false edge
  assign sync_rise = sync_safe_r & ~sync_last_r;

  // resync pulses; the count lets software see that events were applied
  // a disabled resync drops the event, it is not held for later

  always_comb begin
    ch_resync_nxt  = '0;
    resync_cnt_nxt = resync_cnt_r;
    if (sync_rise && ctrl_a_r.resync_en) begin
      ch_resync_nxt  = CH_FROM_SYNTH2_IN; // RULE2
      resync_cnt_nxt = resync_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ch_resync_r  <= '0;
      resync_cnt_r <= 8'h00;
    end else begin
      ch_resync_r  <= ch_resync_nxt;
      resync_cnt_r <= resync_cnt_nxt;
    end
  end

  assign CH_RESYNC_OUT = ch_resync_r;

  // analog control outputs, registered so the pins never glitch
  logic       enable_r, enable_nxt;
  logic       cal_rst_r, cal_rst_nxt;
  logic       cal_busy_r, cal_busy_nxt;
  logic [3:0] div_ratio_r, div_ratio_nxt;
  logic [4:0] pump_r, pump_nxt;
  logic       dbl_r, dbl_nxt;

  always_comb begin
    enable_nxt    = cal_stat.enabled; // RULE3 RULE4
    cal_rst_nxt   = cal_stat.cal_reset; // RULE3
    cal_busy_nxt  = cal_stat.busy; // RULE4
    div_ratio_nxt = post_div_ratio(ctrl_a_r.post_div); // RULE1
    pump_nxt      = pump_units(ctrl_b_r.pump); // RULE7
    dbl_nxt       = ctrl_b_r.dbl; // RULE6
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      // synth held off and calibration in reset until the sequencer runs
      enable_r    <= 1'b0;
      cal_rst_r   <= 1'b1;
      cal_busy_r  <= 1'b0;
      div_ratio_r <= `S2C_DIV_MIN_RATIO;
      pump_r      <= `S2C_PUMP_OFF_UNITS;
      dbl_r       <= `S2C_RST_DBL;
    end else begin
      enable_r    <= enable_nxt;
      cal_rst_r   <= cal_rst_nxt;
      cal_busy_r  <= cal_busy_nxt;
      div_ratio_r <= div_ratio_nxt;
      pump_r      <= pump_nxt;
      dbl_r       <= dbl_nxt;
    end
  end

  assign SYNTH2_ENABLE_OUT            = enable_r;
  assign SYNTH2_CAL_RESET_OUT         = cal_rst_r;
  assign SYNTH2_CAL_BUSY_OUT          = cal_busy_r;
  assign SYNTH2_POST_DIV_RATIO_OUT    = div_ratio_r;
  assign SYNTH2_PUMP_CURRENT_OUT      = pump_r;
  assign SECONDARY_REF_DOUBLER_EN_OUT = dbl_r;
  assign HRESP_OUT                    = resp_r;

  // response is always okay, so registering it costs no bus cycle
  always_comb begin
    resp_nxt = bus_resp;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      resp_r <= `S2C_HRESP_OKAY;
    end else begin
      resp_r <= resp_nxt;
    end
  end

endmodule

/* File: verif/s2c_monitor.sv */
`timescale 1ns/100ps
module s2c_monitor #(
  parameter int NUM_CH     = 8,
  parameter int CAL_CYCLES = 1024
) (
  // clock and reset
  input wire logic              REF_CLK_IN,
  input wire logic              RESETN_IN,
  // bus
  input wire logic              HSEL_IN,
  input wire logic [1:0]        HTRANS_IN,
  input wire logic              HWRITE_IN,
  input wire logic              HREADY_IN,
  input wire logic              HREADYOUT_OUT,
  input wire logic              HRESP_OUT,
  // synchronization
  input wire logic              SYNC_EVENT_IN,
  input wire logic [NUM_CH-1:0] CH_FROM_SYNTH2_IN,
  input wire logic [NUM_CH-1:0] CH_RESYNC_OUT,
  // synthesizer controls
  input wire logic              SYNTH2_ENABLE_OUT,
  input wire logic              SYNTH2_CAL_RESET_OUT,
  input wire logic              SYNTH2_CAL_BUSY_OUT,
  input wire logic [3:0]        SYNTH2_POST_DIV_RATIO_OUT,
  input wire logic [4:0]        SYNTH2_PUMP_CURRENT_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  logic [15:0] busy_cnt_r;
  logic [15:0] busy_cnt_nxt;
  logic        take;

  assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1];

  // a stuck sequencer would hold busy forever; count its length
  always_comb begin
    busy_cnt_nxt = SYNTH2_CAL_BUSY_OUT ? busy_cnt_r + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  property p_ratio; SYNTH2_POST_DIV_RATIO_OUT inside {[4'h2:4'h8]}; endproperty
  a_ratio: assert property (p_ratio) else $error("post divider ratio out of range");
  property p_pump; SYNTH2_PUMP_CURRENT_OUT inside {[5'h00:5'h07], 5'h10}; endproperty
  a_pump: assert property (p_pump) else $error("pump current illegal");
  property p_en_cal; SYNTH2_ENABLE_OUT == !SYNTH2_CAL_RESET_OUT; endproperty
  a_en_cal: assert property (p_en_cal) else $error("enable and cal reset disagree");
  property p_off_idle; !SYNTH2_ENABLE_OUT |-> !SYNTH2_CAL_BUSY_OUT; endproperty
  a_off_idle: assert property (p_off_idle) else $error("calibrating while disabled");
  property p_busy_len; SYNTH2_CAL_BUSY_OUT |-> busy_cnt_r <= 16'(CAL_CYCLES); endproperty
  a_busy_len: assert property (p_busy_len) else $error("calibration too long");
  property p_pulse; |CH_RESYNC_OUT |=> CH_RESYNC_OUT == '0; endproperty
  a_pulse: assert property (p_pulse) else $error("resync pulse too long");
  property p_subset; |CH_RESYNC_OUT |-> CH_RESYNC_OUT == $past(CH_FROM_SYNTH2_IN); endproperty
  a_subset: assert property (p_subset) else $error("resync hit wrong channels");
  property p_no_event; !SYNC_EVENT_IN [*8] |=> CH_RESYNC_OUT == '0; endproperty
  a_no_event: assert property (p_no_event) else $error("resync without event");
  property p_rd_wait; take && !HWRITE_IN |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_fast; take && HWRITE_IN |=> HREADYOUT_OUT && !HRESP_OUT; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write not zero wait");

  c_read: cover property (take && !HWRITE_IN);
  c_cal_done: cover property ($fell(SYNTH2_CAL_BUSY_OUT) && SYNTH2_ENABLE_OUT);
  c_resync: cover property (|CH_RESYNC_OUT);
endmodule

bind s2c_top s2c_monitor #(.NUM_CH(NUM_CH), .CAL_CYCLES(CAL_CYCLES)) s2c_monitor_inst (
  .REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .HSEL_IN(HSEL_IN),
  .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .SYNC_EVENT_IN(SYNC_EVENT_IN),
  .CH_FROM_SYNTH2_IN(CH_FROM_SYNTH2_IN), .CH_RESYNC_OUT(CH_RESYNC_OUT),
  .SYNTH2_ENABLE_OUT(SYNTH2_ENABLE_OUT), .SYNTH2_CAL_RESET_OUT(SYNTH2_CAL_RESET_OUT),
  .SYNTH2_CAL_BUSY_OUT(SYNTH2_CAL_BUSY_OUT),
  .SYNTH2_POST_DIV_RATIO_OUT(SYNTH2_POST_DIV_RATIO_OUT),
  .SYNTH2_PUMP_CURRENT_OUT(SYNTH2_PUMP_CURRENT_OUT));

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`include "s2c_defines.svh"
module testbench;
  localparam logic [31:0] ADR_A = {`S2C_IDX_CTRL_A, 2'b00};
  localparam logic [31:0] ADR_B = {`S2C_IDX_CTRL_B, 2'b00};
  localparam logic [31:0] ADR_S = {`S2C_IDX_STATUS, 2'b00};
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        sync_ev;
  logic [7:0]  ch_src;
  logic [7:0]  ch_rs;
  logic        en;
  logic        cal_rst;
  logic        busy;
  logic        dbl;
  logic [3:0]  ratio;
  logic [4:0]  pump;
  logic [31:0] q;
  int          bad_count;
  int          num_checks;

  s2c_top #(.NUM_CH(8), .CAL_CYCLES(4)) s2c_top_inst (
    .REF_CLK_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HREADYOUT_OUT(hready), .HRDATA_OUT(hrdata), .HRESP_OUT(hresp),
    .SYNC_EVENT_IN(sync_ev), .CH_FROM_SYNTH2_IN(ch_src), .CH_RESYNC_OUT(ch_rs),
    .SYNTH2_ENABLE_OUT(en), .SYNTH2_CAL_RESET_OUT(cal_rst), .SYNTH2_CAL_BUSY_OUT(busy),
    .SYNTH2_POST_DIV_RATIO_OUT(ratio), .SYNTH2_PUMP_CURRENT_OUT(pump),
    .SECONDARY_REF_DOUBLER_EN_OUT(dbl));

  always #2 clk = ~clk;

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h got %h", name, exp, got);
    end
  endtask

  // bounded wait for a level; sampled values are those before the edge
  task wait_lvl(input string name, input int sel, input logic v);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if ((sel == 0 ? hready : busy) === v) begin
        return;
      end
    end
    chk(name, 32'(v), 32'(~v));
    close_out();
  endtask

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_lvl("hready", 0, 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    wait_lvl("hready", 0, 1'b1);
    q = hrdata;
  endtask

  task rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(name, exp, q);
  endtask

  task t_reset;
    repeat (2) @(posedge clk);
    chk("ratio", 32'h0000_0008, 32'(ratio));
    chk("pump", 32'h0000_0010, 32'(pump));
    chk("doubler", 32'h0000_0001, 32'(dbl));
    wait_lvl("busy", 1, 1'b1);
    chk("enable", 32'h0000_0001, 32'(en));
    rd_chk("ctrl_a", ADR_A, 32'h0000_001E);
    rd_chk("ctrl_b", ADR_B, 32'h0000_0018);
    wait_lvl("busy", 1, 1'b0);
    $display("test reset done");
  endtask

  task t_div;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, ADR_A, {27'h7FF_FFFF, c[2:0], 2'b10});
      repeat (2) @(posedge clk);
      chk("ratio", 32'((c < 2) ? 2 : c + 1), 32'(ratio));
      rd_chk("ctrl_a", ADR_A, {27'h0, c[2:0], 2'b10});
    end
    $display("test divider done");
  endtask

  task t_pump;
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, ADR_B, {24'hFF_FFFF, 2'b11, c[1:0], c[3:0]});
      repeat (2) @(posedge clk);
      chk("pump", 32'((c >= 1 && c <= 7) ? c : (c == 8 ? 16 : 0)), 32'(pump));
      chk("doubler", 32'(c[0]), 32'(dbl));
      rd_chk("ctrl_b", ADR_B, {26'h0, c[1:0], c[3:0]});
    end
    // zero data, so a write that aliased onto ctrl_b would show below
    bus(1'b1, 32'h0000_0140, 32'h0000_0000);
    rd_chk("unmapped", 32'h0000_0140, 32'h0000_0000);
    rd_chk("ctrl_b", ADR_B, 32'h0000_003F);
    $display("test pump done");
  endtask

  task t_pdn;
    bus(1'b1, ADR_A, 32'h0000_001F);
    repeat (3) @(posedge clk);
    chk("enable", 32'h0000_0000, 32'(en));
    chk("cal_reset", 32'h0000_0001, 32'(cal_rst));
    rd_chk("status", ADR_S, 32'h0000_0008);
    bus(1'b1, ADR_A, 32'h0000_001E);
    wait_lvl("busy", 1, 1'b1);
    chk("enable", 32'h0000_0001, 32'(en));
    chk("cal_reset", 32'h0000_0000, 32'(cal_rst));
    wait_lvl("busy", 1, 1'b0);
    $display("test power down done");
  endtask

  task t_sync(input logic on, input logic [7:0] n);
    logic [7:0] seen;
    bus(1'b1, ADR_A, {27'h0, 3'h7, on, 1'b0});
    repeat (2) @(posedge clk);
    seen = 8'h00;
    sync_ev <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      seen = seen | ch_rs;
    end
    sync_ev <= 1'b0;
    chk("resync", on ? 32'h0000_00A5 : 32'h0000_0000, 32'(seen));
    repeat (3) @(posedge clk);
    rd_chk("status", ADR_S, {16'h0000, n, 8'h05});
    $display("test sync done");
  endtask

  initial begin
    #200000;
    chk("run time", 32'h0000_0000, 32'h0000_0001);
    close_out();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    sync_ev = 1'b0;
    ch_src = 8'hA5;
    bad_count = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_div();
    t_pump();
    t_pdn();
    t_sync(1'b1, 8'h01);
    t_sync(1'b0, 8'h01);
    // a second reset must restore every control field, not only the first time
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    close_out();
  end
endmodule
